/* File: design/irmp_pkg.sv */
// constants, types and register map of the ir motion/proximity controller
// assumes a single 250 MHz clock and an i2c host on open-drain scl/sda pins
// Overview of operation
// - mode bit clear runs horizontal motion detection on both photodiode channels.
// - mode bit set runs proximity detection instead of motion detection.
// - current field 000=400mA, 001=280mA, 01x=210mA, 1xx=70mA drive.
// - motion result field holds meaningful values only in motion mode.
// - motion 01 second-to-first, 10 first-to-second, others no motion.
// - proximity result field holds meaningful values only in proximity mode.
// - proximity 01 moving away, 10 approaching, others no motion.
// - alert pin goes low whenever a motion or proximity result changes.
// - reading the status register returns the alert pin high.
// - alert low for 10 ms without status read releases itself.
// - stable state emitter average current is 1/512 of selected drive.
// - active motion detection emitter average current is 1/8 of drive.
// - active proximity detection keeps the stable-state emitter duty.
// - register contents are kept through software and hardware shutdown.
// - writing the software shutdown bit as zero enters software shutdown.
// - powerdown pin held low enters hardware shutdown, stopping all sensing.
// - device acknowledges address, register byte and each written data byte.
package irmp_pkg;
    localparam logic [7:0] REG_RESULT = 8'h00;
    localparam logic [7:0] REG_PWRDN  = 8'h01;
    localparam logic [7:0] REG_CONFIG = 8'h11;
    localparam logic [7:0] RST_PWRDN  = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RD_NONE    = 8'h00;
    localparam int PWRDN_RUN_BIT = 0;
    localparam int CFG_MODE_BIT  = 0;
    localparam int CFG_EC_LSB    = 1;
    localparam int CFG_EC_MSB    = 3;
    localparam logic [1:0] RES_NONE = 2'h0;
    localparam logic [1:0] LVL_400MA = 2'h0;
    localparam logic [1:0] LVL_280MA = 2'h1;
    localparam logic [1:0] LVL_210MA = 2'h2;
    localparam logic [1:0] LVL_70MA  = 2'h3;
    localparam logic [8:0] DUTY_PERIOD_M1 = 9'h1FF;
    localparam logic [8:0] DUTY_STABLE_ON = 9'h001;
    localparam logic [8:0] DUTY_MOTION_ON = 9'h040;
    localparam int CLK_MHZ          = 250;
    localparam int ALERT_TIMEOUT_MS = 10;
    localparam int ALERT_TIMEOUT_CYC = ALERT_TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam logic [6:0] DEV_ADDR_DEF = 7'h2A;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef struct packed {
        logic [2:0] emit_current_sel;
        logic       prox_mode;
    } irmp_cfg_t;

    typedef struct packed {
        logic [1:0] proximity_result;
        logic [1:0] motion_result;
    } irmp_res_t;

    typedef enum logic [8:0] {
        I2C_IDLE  = 9'h001,
        I2C_ADDR  = 9'h002,
        I2C_AACK  = 9'h004,
        I2C_REG   = 9'h008,
        I2C_RACK  = 9'h010,
        I2C_WDATA = 9'h020,
        I2C_WACK  = 9'h040,
        I2C_RDATA = 9'h080,
        I2C_MACK  = 9'h100
    } irmp_i2c_st_t;
endpackage

/* File: design/irmp_ctrl.sv */
// top of the ir motion/proximity controller: i2c slave, registers,
// alert pin, emitter duty and shutdown control
// assumes scl/sda/powerdown pins are asynchronous and sensing results
// arrive from the analog front end on clk_sys
`timescale 1ns/100ps
module irmp_ctrl #(
    parameter logic [6:0] DEV_ADDR      = irmp_pkg::DEV_ADDR_DEF,
    parameter int         ALERT_CYCLES  = irmp_pkg::ALERT_TIMEOUT_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       hw_powerdown_n,
    input  wire logic       sense_valid,
    input  wire logic [1:0] sense_code,
    input  wire logic       sense_active,
    output logic            motion_alert_n,
    output logic            ir_emitter_drive,
    output logic [1:0]      ir_drive_level,
    output logic            first_photodiode_en,
    output logic            second_photodiode_en,
    output logic            sense_enable
);
    // pin synchronisers: stage one is read only by stage two
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic       scl_prev_q;
    logic       sda_prev_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sync1_q    <= 3'h7;
            sync2_q    <= 3'h7;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else if (clk_en) begin
            sync1_q    <= {hw_powerdown_n, sda_in, scl_in};
            sync2_q    <= sync1_q;
            scl_prev_q <= sync2_q[0];
            sda_prev_q <= sync2_q[1];
        end
    end

    wire scl_s    = sync2_q[0];
    wire sda_s    = sync2_q[1];
    wire pd_pin_n = sync2_q[2];
    wire scl_rise = scl_s & ~scl_prev_q;
    wire scl_fall = ~scl_s & scl_prev_q;
    wire i2c_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    wire i2c_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    // start and stop only count while scl stays high on both samples; an sda
    // move with scl low is ordinary data and must not disturb a byte in flight
    // the edge flops reset to the idle level of the pins, so no false edge or
    // false start follows the release of reset
    // limitation: scl and sda are sampled on clk_sys only, so every scl phase
    // must last well over three clk_sys cycles for the pipeline to see it

    // registers
    // power_down_control keeps only its run bit and operating_config only its
    // mode and current fields; the other bits are not stored and read as zero
    irmp_pkg::irmp_cfg_t cfg_q;
    irmp_pkg::irmp_res_t res_q;
    logic                run_q;

    wire soft_down = ~run_q;
    wire hard_down = ~pd_pin_n;
    wire shutdown  = soft_down | hard_down;
    // either shutdown stops sensing, emitter and alert, but the i2c slave keeps
    // running so the host can still end a software shutdown by a write

    // i2c slave state
    irmp_pkg::irmp_i2c_st_t st_q;
    irmp_pkg::irmp_i2c_st_t st_d;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic       rw_q;
    logic       rw_d;
    logic       drv_q;
    logic       drv_d;
    logic       wr_stb;
    logic       rd_load;

    wire byte_full = (bit_q == irmp_pkg::BITS_PER_BYTE);
    wire addr_hit  = (sh_q[7:1] == DEV_ADDR);
    wire ptr_res   = (ptr_q == irmp_pkg::REG_RESULT);
    wire ptr_pwr   = (ptr_q == irmp_pkg::REG_PWRDN);
    wire ptr_cfg   = (ptr_q == irmp_pkg::REG_CONFIG);

    // only the result register reads back; write-only ones read as zero
    // a status read is counted when the byte is loaded for sending, not when
    // the host acknowledges it, so the alert is already high by the stop
    wire [7:0] rd_data = ptr_res ? {4'h0, res_q} : irmp_pkg::RD_NONE;
    wire       status_read = rd_load & ptr_res;

    always_comb begin
        st_d    = st_q;
        bit_d   = bit_q;
        sh_d    = sh_q;
        ptr_d   = ptr_q;
        rw_d    = rw_q;
        drv_d   = drv_q;
        wr_stb  = 1'b0;
        rd_load = 1'b0;
        if (i2c_start) begin
            st_d  = irmp_pkg::I2C_ADDR;
            bit_d = 4'h0;
            drv_d = 1'b0;
        end else if (i2c_stop) begin
            st_d  = irmp_pkg::I2C_IDLE;
            drv_d = 1'b0;
        end else begin
            unique case (st_q)
                irmp_pkg::I2C_IDLE: begin
                    drv_d = 1'b0;
                end
                irmp_pkg::I2C_ADDR,
                irmp_pkg::I2C_REG,
                irmp_pkg::I2C_WDATA: begin
                    if (scl_rise && !byte_full) begin
                        sh_d  = {sh_q[6:0], sda_s};
                        bit_d = bit_q + 4'h1;
                    end
                    if (scl_fall && byte_full) begin
                        bit_d = 4'h0;
                        drv_d = 1'b1;
                        if (st_q == irmp_pkg::I2C_ADDR) begin
                            rw_d = sh_q[0];
                            st_d = irmp_pkg::I2C_AACK;
                            if (!addr_hit) begin
                                drv_d = 1'b0;
                                st_d  = irmp_pkg::I2C_IDLE;
                            end
                        end else if (st_q == irmp_pkg::I2C_REG) begin
                            ptr_d = sh_q;
                            st_d  = irmp_pkg::I2C_RACK;
                        end else begin
                            wr_stb = 1'b1;
                            st_d   = irmp_pkg::I2C_WACK;
                        end
                    end
                end
                irmp_pkg::I2C_AACK: begin
                    // a read continues here after each host acknowledge
                    if (scl_fall) begin
                        if (rw_q) begin
                            rd_load = 1'b1;
                            sh_d    = rd_data;
                            drv_d   = ~rd_data[7];
                            bit_d   = 4'h1;
                            st_d    = irmp_pkg::I2C_RDATA;
                        end else begin
                            drv_d = 1'b0;
                            st_d  = irmp_pkg::I2C_REG;
                        end
                    end
                end
                irmp_pkg::I2C_RACK,
                irmp_pkg::I2C_WACK: begin
                    // further data bytes go to the same register
                    if (scl_fall) begin
                        drv_d = 1'b0;
                        st_d  = irmp_pkg::I2C_WDATA;
                    end
                end
                irmp_pkg::I2C_RDATA: begin
                    if (scl_fall) begin
                        if (byte_full) begin
                            drv_d = 1'b0;
                            st_d  = irmp_pkg::I2C_MACK;
                        end else begin
                            sh_d  = {sh_q[6:0], 1'b0};
                            drv_d = ~sh_q[6];
                            bit_d = bit_q + 4'h1;
                        end
                    end
                end
                irmp_pkg::I2C_MACK: begin
                    if (scl_rise) begin
                        st_d = sda_s ? irmp_pkg::I2C_IDLE : irmp_pkg::I2C_AACK;
                    end
                end
                default: begin
                    st_d  = irmp_pkg::I2C_IDLE;
                    drv_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_q  <= irmp_pkg::I2C_IDLE;
            bit_q <= 4'h0;
            sh_q  <= 8'h00;
            ptr_q <= 8'h00;
            rw_q  <= 1'b0;
            drv_q <= 1'b0;
        end else if (clk_en) begin
            st_q  <= st_d;
            bit_q <= bit_d;
            sh_q  <= sh_d;
            ptr_q <= ptr_d;
            rw_q  <= rw_d;
            drv_q <= drv_d;
        end
    end

    // open drain: only ever pull low
    // the enable comes from a flop and only moves three cycles after an scl
    // fall, so sda never changes while the host holds scl high
    assign sda_out = 1'b0;
    assign sda_oe  = drv_q;

    // register writes; shutdown never touches them
    // a data byte is taken at the scl fall after its eighth bit, so a stop or
    // start in the middle of a byte leaves the registers as they were
    wire wr_pwr = wr_stb & ptr_pwr;
    wire wr_cfg = wr_stb & ptr_cfg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            run_q <= irmp_pkg::RST_PWRDN[irmp_pkg::PWRDN_RUN_BIT];
            cfg_q <= irmp_pkg::irmp_cfg_t'(irmp_pkg::RST_CONFIG[3:0]);
        end else if (clk_en) begin
            if (wr_pwr) begin
                run_q <= sh_q[irmp_pkg::PWRDN_RUN_BIT];
            end
            if (wr_cfg) begin
                cfg_q.prox_mode <= sh_q[irmp_pkg::CFG_MODE_BIT];
                cfg_q.emit_current_sel <= sh_q[irmp_pkg::CFG_EC_MSB:irmp_pkg::CFG_EC_LSB];
            end
        end
    end

    // result capture: each valid code writes the field of the inactive mode as no motion
    // codes are compared after the inactive field is forced, so a mode change
    // alone raises no alert, but the next valid nonzero code then alerts even if unchanged
    wire sense_take = sense_valid & ~shutdown;
    irmp_pkg::irmp_res_t res_new;
    assign res_new.motion_result    = cfg_q.prox_mode ? irmp_pkg::RES_NONE
                                                      : sense_code;
    assign res_new.proximity_result = cfg_q.prox_mode ? sense_code
                                                      : irmp_pkg::RES_NONE;
    wire res_change = sense_take & (res_new != res_q);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            res_q <= '0;
        end else if (clk_en && sense_take) begin
            res_q <= res_new;
        end
    end

    // alert: a change in the same cycle as a status read wins
    // letting the read win would lose a result the host has not yet seen; a
    // fresh change also restarts the self-release count from zero
    logic        alert_q;
    logic [31:0] alert_cnt_q;
    wire alert_expire = alert_q & (alert_cnt_q == 32'(ALERT_CYCLES - 1));

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            alert_q     <= 1'b0;
            alert_cnt_q <= 32'h0;
        end else if (clk_en) begin
            if (shutdown) begin
                alert_q     <= 1'b0;
                alert_cnt_q <= 32'h0;
            end else if (res_change) begin
                alert_q     <= 1'b1;
                alert_cnt_q <= 32'h0;
            end else if (status_read || alert_expire) begin
                alert_q     <= 1'b0;
                alert_cnt_q <= 32'h0;
            end else if (alert_q) begin
                alert_cnt_q <= alert_cnt_q + 32'h1;
            end
        end
    end

    assign motion_alert_n = ~alert_q;

    // emitter duty: one slot in 512, or 64 slots while motion is active
    // the frame counter restarts in shutdown, so the first frame after wake-up
    // begins with its on slot; the drive output lags the counter by one cycle
    logic [8:0] duty_cnt_q;
    wire motion_busy = ~cfg_q.prox_mode & sense_active;
    wire [8:0] duty_on = motion_busy ? irmp_pkg::DUTY_MOTION_ON
                                     : irmp_pkg::DUTY_STABLE_ON;
    wire emit_now = ~shutdown & (duty_cnt_q < duty_on);

    // current decode: highest set bit picks the level
    // the level is a code for the analog driver, held even in shutdown so the
    // emitter comes back at the same current
    wire [2:0] ec = cfg_q.emit_current_sel;
    wire [1:0] level_d = ec[2] ? irmp_pkg::LVL_70MA :
                         ec[1] ? irmp_pkg::LVL_210MA :
                         ec[0] ? irmp_pkg::LVL_280MA :
                                 irmp_pkg::LVL_400MA;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            duty_cnt_q       <= 9'h000;
            ir_emitter_drive <= 1'b0;
            ir_drive_level   <= irmp_pkg::LVL_400MA;
        end else if (clk_en) begin
            if (shutdown || duty_cnt_q == irmp_pkg::DUTY_PERIOD_M1) begin
                duty_cnt_q <= 9'h000;
            end else begin
                duty_cnt_q <= duty_cnt_q + 9'h001;
            end
            ir_emitter_drive <= emit_now;
            ir_drive_level   <= level_d;
        end
    end

    // channel enables for the front end
    // registered so that on entering or leaving shutdown each enable changes on the same edge as sense_enable; in proximity mode the second stays low
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sense_enable         <= 1'b0;
            first_photodiode_en  <= 1'b0;
            second_photodiode_en <= 1'b0;
        end else if (clk_en) begin
            sense_enable         <= ~shutdown;
            first_photodiode_en  <= ~shutdown;
            // proximity needs only the first channel's reflectance
            second_photodiode_en <= ~shutdown & ~cfg_q.prox_mode;
        end
    end
endmodule

/* File: sim/irmp_ctrl_asserts.sv */
// port-level assertions for irmp_ctrl
// assumes clk_en held high; bound to the design from the testbench top
`timescale 1ns/100ps
module irmp_ctrl_asserts #(
    parameter int ALERT_CYCLES = 200
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic scl_in,
    input logic      sda_oe,
    input wire logic hw_powerdown_n,
    input wire logic sense_valid,
    input wire logic sense_active,
    input logic      motion_alert_n,
    input logic      ir_emitter_drive,
    input logic      first_photodiode_en,
    input logic      second_photodiode_en,
    input logic      sense_enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [31:0] low_q;
    logic [31:0] on_q;
    // run lengths of alert low and emitter on
    always_ff @(posedge clk_sys) begin
        low_q <= (sys_rst || motion_alert_n) ? 32'h0 : low_q + 32'h1;
        on_q  <= (sys_rst || !ir_emitter_drive) ? 32'h0 : on_q + 32'h1;
    end
    alert_timeout_a: assert property (low_q <= ALERT_CYCLES + 2)
        else $error("alert held low too long");
    motion_duty_a: assert property (on_q <= 32'h40)
        else $error("emitter on longer than a motion burst");
    stable_duty_a: assert property ((sense_enable && !sense_active)[*4]
        |-> !(ir_emitter_drive && $past(ir_emitter_drive))) else $error("stable duty broken");
    prox_duty_a: assert property ((sense_enable && !second_photodiode_en)[*4]
        |-> !(ir_emitter_drive && $past(ir_emitter_drive))) else $error("proximity duty broken");
    hw_shdn_a: assert property (!hw_powerdown_n[*6] |-> !sense_enable && !ir_emitter_drive)
        else $error("sensing active with powerdown pin low");
    quiet_shdn_a: assert property (!sense_enable[*2] |-> !ir_emitter_drive && motion_alert_n
        && !first_photodiode_en && !second_photodiode_en) else $error("activity in shutdown");
    alert_cause_a: assert property ($fell(motion_alert_n)
        |-> $past(sense_valid) || $past(sense_valid, 2)) else $error("alert without result");
    ack_edge_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("sda drive changed while scl high");
    probe_on_a: assert property (sense_enable && $past(sense_enable) |-> first_photodiode_en)
        else $error("first channel off while sensing");
endmodule

/* File: sim/irmp_host_model.sv */
// i2c host model: drives scl, pulls sda low or releases it
// assumes a pull-up on sda; the device pulls sda only through its enable
`timescale 1ns/100ps
module irmp_host_model #(
    parameter logic [6:0] DEV  = irmp_pkg::DEV_ADDR_DEF,
    parameter int         HALF = 12
) (
    input wire logic clk_sys,
    input wire logic sda_in,
    output logic     scl,
    output logic     sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // sda only moves a few cycles after scl falls, never with it
    task automatic bitx(input logic b, output logic r);
        tick(4);
        sda_low <= !b;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        r = sda_in;
        scl <= 1'b0;
    endtask
    // a=1: start or repeated start, a=0: stop
    task automatic cond(input logic a);
        tick(4);
        sda_low <= !a;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_low <= a;
        tick(HALF);
        if (a) scl <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
            q[i] = r;
        end
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] wd,
                      output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        cond(1'b1);
        xfer({dev, 1'b0}, q, a0);
        xfer(ra, q, a1);
        xfer(wd, q, a2);
        cond(1'b0);
        ok = a0 && a1 && a2;
    endtask
    // single-byte read, ended by a nack from the host
    task automatic rd(input logic [7:0] ra, output logic [7:0] rd_data);
        logic [7:0] q;
        logic a;
        cond(1'b1);
        xfer({DEV, 1'b0}, q, a);
        xfer(ra, q, a);
        cond(1'b1);
        xfer({DEV, 1'b1}, q, a);
        xfer(8'hFF, rd_data, a);
        cond(1'b0);
    endtask
endmodule

/* File: sim/tb.sv */
// self-checking testbench for irmp_ctrl
// assumes the host model owns scl and its share of sda
`timescale 1ns/100ps
module tb;
    // long enough that a status read always lands before the self-release
    localparam int         ALERT_CYCLES = 2000;
    localparam logic [6:0] DEV          = irmp_pkg::DEV_ADDR_DEF;
    logic       clk_sys = 1'b0;
    logic       sys_rst = 1'b1;
    logic       hw_powerdown_n = 1'b1;
    logic       sense_valid = 1'b0;
    logic [1:0] sense_code = 2'h0;
    logic       sense_active = 1'b0;
    logic       scl, sda_low, sda_out, sda_oe, motion_alert_n, ir_emitter_drive;
    logic       first_photodiode_en, second_photodiode_en, sense_enable;
    logic [1:0] ir_drive_level;
    int         fails = 0;
    int         n_checks = 0;
    wire        sda = !(sda_low || (sda_oe && !sda_out));
    irmp_ctrl #(.ALERT_CYCLES(ALERT_CYCLES)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .clk_en(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .hw_powerdown_n(hw_powerdown_n), .sense_valid(sense_valid), .sense_code(sense_code),
        .sense_active(sense_active), .motion_alert_n(motion_alert_n),
        .ir_emitter_drive(ir_emitter_drive), .ir_drive_level(ir_drive_level),
        .first_photodiode_en(first_photodiode_en),
        .second_photodiode_en(second_photodiode_en), .sense_enable(sense_enable));
    irmp_host_model host (.clk_sys(clk_sys), .sda_in(sda), .scl(scl), .sda_low(sda_low));
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    function automatic logic [1:0] lvl(input logic [2:0] e);
        lvl = e[2] ? irmp_pkg::LVL_70MA : e[1] ? irmp_pkg::LVL_210MA
            : e[0] ? irmp_pkg::LVL_280MA : irmp_pkg::LVL_400MA;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic sense(input logic [1:0] c);
        @(posedge clk_sys);
        sense_valid <= 1'b1;
        sense_code <= c;
        @(posedge clk_sys);
        sense_valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    // two whole 512-cycle frames, so the count is phase independent
    task automatic duty(input logic [7:0] exp);
        int n;
        n = 0;
        repeat (600) @(posedge clk_sys);
        repeat (1024) begin
            @(posedge clk_sys);
            n += ir_emitter_drive;
        end
        chk(8'(n), exp);
    endtask
    initial begin
        repeat (90000) @(posedge clk_sys);
        fails++;
        close_out();
    end
    initial begin
        logic [7:0] d, res, exp;
        logic [1:0] c;
        logic       ok, mode;
        void'($urandom(7));
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        sense(2'h1);
        chk({7'h0, motion_alert_n}, 8'h01);
        chk({7'h0, sense_enable}, 8'h00);
        host.wr(DEV ^ 7'h01, irmp_pkg::REG_PWRDN, 8'h01, ok);
        chk({7'h0, ok}, 8'h00);
        host.wr(DEV, irmp_pkg::REG_PWRDN, 8'h01, ok);
        chk({7'h0, sense_enable}, 8'h01);
        for (int e = 0; e < 8; e++) begin
            host.wr(DEV, irmp_pkg::REG_CONFIG, {4'h0, 3'(e), 1'b0}, ok);
            chk({7'h0, ok}, 8'h01);
            chk({6'h0, ir_drive_level}, {6'h0, lvl(3'(e))});
            chk({7'h0, second_photodiode_en}, 8'h01);
        end
        res = irmp_pkg::RD_NONE;
        for (int i = 0; i < 16; i++) begin
            mode = (i < 8) ? 1'(i >> 2) : 1'($urandom);
            c = (i < 8) ? 2'(i) : 2'($urandom);
            host.wr(DEV, irmp_pkg::REG_CONFIG, {7'h0, mode}, ok);
            sense(c);
            exp = mode ? {4'h0, c, 2'h0} : {6'h0, c};
            chk({7'h0, motion_alert_n}, {7'h0, exp == res});
            res = exp;
            host.rd(irmp_pkg::REG_RESULT, d);
            chk(d, res);
            chk({7'h0, motion_alert_n}, 8'h01);
        end
        sense(~(mode ? res[3:2] : res[1:0]));
        repeat (ALERT_CYCLES - 20) @(posedge clk_sys);
        chk({7'h0, motion_alert_n}, 8'h00);
        repeat (40) @(posedge clk_sys);
        chk({7'h0, motion_alert_n}, 8'h01);
        host.rd(8'h05, d);
        chk(d, 8'h00);
        host.wr(DEV, irmp_pkg::REG_CONFIG, 8'h00, ok);
        sense_active <= 1'b1;
        duty(8'h80);
        sense_active <= 1'b0;
        duty(8'h02);
        host.wr(DEV, irmp_pkg::REG_CONFIG, 8'h03, ok);
        sense_active <= 1'b1;
        duty(8'h02);
        chk({7'h0, second_photodiode_en}, 8'h00);
        hw_powerdown_n <= 1'b0;
        duty(8'h00);
        chk({7'h0, sense_enable}, 8'h00);
        hw_powerdown_n <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk({6'h0, ir_drive_level}, {6'h0, irmp_pkg::LVL_280MA});
        chk({7'h0, second_photodiode_en}, 8'h00);
        host.wr(DEV, irmp_pkg::REG_PWRDN, 8'h00, ok);
        sense(2'h2);
        chk({7'h0, motion_alert_n}, 8'h01);
        chk({7'h0, sense_enable}, 8'h00);
        host.wr(DEV, irmp_pkg::REG_PWRDN, 8'h01, ok);
        chk({6'h0, ir_drive_level}, {6'h0, irmp_pkg::LVL_280MA});
        close_out();
    end
endmodule
bind irmp_ctrl irmp_ctrl_asserts #(.ALERT_CYCLES(ALERT_CYCLES)) u_chk (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .scl_in(scl_in), .sda_oe(sda_oe), .hw_powerdown_n(hw_powerdown_n),
    .sense_valid(sense_valid), .sense_active(sense_active), .motion_alert_n(motion_alert_n),
    .ir_emitter_drive(ir_emitter_drive), .first_photodiode_en(first_photodiode_en),
    .second_photodiode_en(second_photodiode_en), .sense_enable(sense_enable));
